// File: hw/pims_pkg.sv
package pims_pkg;

  localparam int COND_W = 4;
  localparam int LVL_W = 16;
  localparam int REF_W = 32;
  localparam int PIT_W = 16;

  // Condition-select lowest digit encodings
  localparam logic [3:0] COND_TORQUE = 4'h0;
  localparam logic [3:0] COND_SPEED = 4'h1;
  localparam logic [3:0] COND_ACCEL = 4'h2;
  localparam logic [3:0] COND_DEV = 4'h3;
  localparam logic [3:0] COND_OFF = 4'h4;

  // Reset values and ranges
  localparam logic [3:0] COND_RST = 4'h0;
  localparam logic [15:0] TORQUE_LVL_RST = 16'h00c8;
  localparam logic [15:0] TORQUE_LVL_MAX = 16'h0320;
  localparam logic [15:0] SPEED_LVL_RST = 16'h0000;
  localparam logic [15:0] SPEED_LVL_MAX = 16'h2710;
  localparam logic [15:0] ACCEL_LVL_RST = 16'h0000;
  localparam logic [15:0] ACCEL_LVL_MAX = 16'h7530;
  localparam logic [15:0] DEV_LVL_RST = 16'h0000;
  localparam logic [15:0] DEV_LVL_MAX = 16'h2710;
  localparam logic [15:0] PIT_RST = 16'h0000;
  localparam logic [15:0] PIT_MAX = 16'hc350;

endpackage

// File: hw/pims_top.sv
`timescale 1ns/1ps
`default_nettype none

module pims_top #(
  parameter int REF_W = pims_pkg::REF_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] switch_condition_select,
  input wire logic [15:0] torque_switch_level,
  input wire logic [15:0] rotary_speed_switch_level,
  input wire logic [15:0] rotary_accel_switch_level,
  input wire logic [15:0] deviation_switch_level,
  input wire logic [15:0] linear_speed_switch_level,
  input wire logic [15:0] linear_accel_switch_level,
  input wire logic [15:0] position_integral_time,
  input wire logic linear_motor,
  input wire logic position_mode,
  input wire logic cfg_load,
  input wire logic signed [REF_W-1:0] torque_ref,
  input wire logic signed [REF_W-1:0] speed_ref,
  input wire logic signed [REF_W-1:0] accel_ref,
  input wire logic signed [REF_W-1:0] position_dev,
  output logic p_only,
  output logic pos_integral_en,
  output logic [15:0] pos_integral_time_out,
  output logic cfg_range_err
);

  // Magnitudes are compared with zero-extended levels, so the reference must be wider than a level
  if (REF_W < 17)
  begin : g_bad_ref_w
    $error("REF_W must exceed the 16-bit level width");
  end

  // Settings held in the block; loaded on cfg_load, range-checked
  logic [3:0] cond_ff, nxt_cond;
  logic [15:0] tq_lvl_ff, nxt_tq_lvl;
  logic [15:0] rs_lvl_ff, nxt_rs_lvl;
  logic [15:0] ra_lvl_ff, nxt_ra_lvl;
  logic [15:0] dv_lvl_ff, nxt_dv_lvl;
  logic [15:0] ls_lvl_ff, nxt_ls_lvl;
  logic [15:0] la_lvl_ff, nxt_la_lvl;
  logic [15:0] pit_ff, nxt_pit;
  logic err_ff, nxt_err;
  logic range_bad;

  always_comb
  begin
    range_bad = (switch_condition_select > pims_pkg::COND_OFF)
      || (torque_switch_level > pims_pkg::TORQUE_LVL_MAX)
      || (rotary_speed_switch_level > pims_pkg::SPEED_LVL_MAX)
      || (linear_speed_switch_level > pims_pkg::SPEED_LVL_MAX)
      || (rotary_accel_switch_level > pims_pkg::ACCEL_LVL_MAX)
      || (linear_accel_switch_level > pims_pkg::ACCEL_LVL_MAX)
      || (deviation_switch_level > pims_pkg::DEV_LVL_MAX)
      || (position_integral_time > pims_pkg::PIT_MAX);
    nxt_cond = cond_ff;
    nxt_tq_lvl = tq_lvl_ff;
    nxt_rs_lvl = rs_lvl_ff;
    nxt_ra_lvl = ra_lvl_ff;
    nxt_dv_lvl = dv_lvl_ff;
    nxt_ls_lvl = ls_lvl_ff;
    nxt_la_lvl = la_lvl_ff;
    nxt_pit = pit_ff;
    nxt_err = err_ff;
    if (cfg_load)
    begin
      // Whole set rejected on any bad field, so settings never mix
      nxt_err = range_bad;
      if (!range_bad)
      begin
        nxt_cond = switch_condition_select;
        nxt_tq_lvl = torque_switch_level;
        nxt_rs_lvl = rotary_speed_switch_level;
        nxt_ra_lvl = rotary_accel_switch_level;
        nxt_dv_lvl = deviation_switch_level;
        nxt_ls_lvl = linear_speed_switch_level;
        nxt_la_lvl = linear_accel_switch_level;
        nxt_pit = position_integral_time;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cond_ff <= pims_pkg::COND_RST;
      tq_lvl_ff <= pims_pkg::TORQUE_LVL_RST;
      rs_lvl_ff <= pims_pkg::SPEED_LVL_RST;
      ra_lvl_ff <= pims_pkg::ACCEL_LVL_RST;
      dv_lvl_ff <= pims_pkg::DEV_LVL_RST;
      ls_lvl_ff <= pims_pkg::SPEED_LVL_RST;
      la_lvl_ff <= pims_pkg::ACCEL_LVL_RST;
      pit_ff <= pims_pkg::PIT_RST;
      err_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      cond_ff <= nxt_cond;
      tq_lvl_ff <= nxt_tq_lvl;
      rs_lvl_ff <= nxt_rs_lvl;
      ra_lvl_ff <= nxt_ra_lvl;
      dv_lvl_ff <= nxt_dv_lvl;
      ls_lvl_ff <= nxt_ls_lvl;
      la_lvl_ff <= nxt_la_lvl;
      pit_ff <= nxt_pit;
      err_ff <= nxt_err;
    end
  end

  // Trigger evaluation; references compared on magnitude
  logic [REF_W-1:0] mag_tq, mag_sp, mag_ac, mag_dv;
  logic [15:0] sp_lvl, ac_lvl;
  logic trig;
  logic p_ff, nxt_p;
  logic pie_ff, nxt_pie;
  logic [15:0] pit_out_ff, nxt_pit_out;

  function automatic logic [REF_W-1:0] absval(input logic signed [REF_W-1:0] v);
    absval = v[REF_W-1] ? REF_W'(-v) : REF_W'(v);
  endfunction

  always_comb
  begin
    mag_tq = absval(torque_ref);
    mag_sp = absval(speed_ref);
    mag_ac = absval(accel_ref);
    mag_dv = absval(position_dev);
    sp_lvl = linear_motor ? ls_lvl_ff : rs_lvl_ff;
    ac_lvl = linear_motor ? la_lvl_ff : ra_lvl_ff;
    trig = 1'b0;
    unique case (cond_ff)
      pims_pkg::COND_TORQUE: trig = mag_tq >= REF_W'(tq_lvl_ff);
      pims_pkg::COND_SPEED: trig = mag_sp >= REF_W'(sp_lvl);
      pims_pkg::COND_ACCEL: trig = mag_ac >= REF_W'(ac_lvl);
      pims_pkg::COND_DEV: trig = position_mode && (mag_dv >= REF_W'(dv_lvl_ff));
      pims_pkg::COND_OFF: trig = 1'b0;
      default: trig = 1'b0;
    endcase
    nxt_p = trig;
    nxt_pie = (pit_ff != 16'h0000);
    nxt_pit_out = pit_ff;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      p_ff <= 1'b0;
      pie_ff <= 1'b0;
      pit_out_ff <= pims_pkg::PIT_RST;
    end
    else if (clk_en)
    begin
      p_ff <= nxt_p;
      pie_ff <= nxt_pie;
      pit_out_ff <= nxt_pit_out;
    end
  end

  assign p_only = p_ff;
  assign pos_integral_en = pie_ff;
  assign pos_integral_time_out = pit_out_ff;
  assign cfg_range_err = err_ff;

  chk_off_never_p: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_OFF |=> !p_only)
    else $error("P-only asserted while switching disabled");
  chk_torque_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_TORQUE && mag_tq >= REF_W'(tq_lvl_ff) |=> p_only)
    else $error("Torque at level did not force P-only");
  chk_speed_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_SPEED && mag_sp >= REF_W'(sp_lvl) |=> p_only)
    else $error("Speed at level did not force P-only");
  chk_accel_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_ACCEL && mag_ac >= REF_W'(ac_lvl) |=> p_only)
    else $error("Acceleration at level did not force P-only");
  chk_dev_posmode: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_DEV && !position_mode |=> !p_only)
    else $error("Deviation acted outside position mode");
  chk_dev_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_DEV && position_mode && mag_dv >= REF_W'(dv_lvl_ff) |=> p_only)
    else $error("Deviation at level did not force P-only");
  chk_return_pi: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_TORQUE && mag_tq < REF_W'(tq_lvl_ff) |=> !p_only)
    else $error("Below threshold did not return to PI");
  chk_torque_range: assert property (@(posedge clock) disable iff (rst)
    tq_lvl_ff <= pims_pkg::TORQUE_LVL_MAX)
    else $error("Torque level out of range");
  chk_pi_zero_off: assert property (@(posedge clock) disable iff (rst)
    clk_en && pit_ff == 16'h0000 |=> !pos_integral_en)
    else $error("Integral enabled with zero time constant");

  // Rotary and linear speed and accel levels are separate settings; each must act alone; force uses the torque level
  chk_rot_speed_lvl: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_SPEED && !linear_motor && mag_sp >= REF_W'(rs_lvl_ff) |=> p_only)
    else $error("Rotary speed level did not force P-only");
  chk_lin_speed_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_SPEED && linear_motor && mag_sp >= REF_W'(ls_lvl_ff) |=> p_only)
    else $error("Linear speed level did not force P-only");
  chk_rot_accel_lvl: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_ACCEL && !linear_motor && mag_ac >= REF_W'(ra_lvl_ff) |=> p_only)
    else $error("Rotary acceleration level did not force P-only");
  chk_lin_accel_trig: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_ACCEL && linear_motor && mag_ac >= REF_W'(la_lvl_ff) |=> p_only)
    else $error("Linear acceleration level did not force P-only");
  chk_force_same_lvl: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_TORQUE && linear_motor && mag_tq >= REF_W'(tq_lvl_ff) |=> p_only)
    else $error("Force at level did not force P-only");

  // Falling below any level must release the loop on the very next cycle
  chk_speed_return: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_SPEED && mag_sp < REF_W'(sp_lvl) |=> !p_only)
    else $error("Speed below level did not return to PI");
  chk_accel_return: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_ACCEL && mag_ac < REF_W'(ac_lvl) |=> !p_only)
    else $error("Acceleration below level did not return to PI");
  chk_dev_return: assert property (@(posedge clock) disable iff (rst)
    clk_en && cond_ff == pims_pkg::COND_DEV && mag_dv < REF_W'(dv_lvl_ff) |=> !p_only)
    else $error("Deviation below level did not return to PI");

  // Settings load as one set or not at all
  chk_load_takes: assert property (@(posedge clock) disable iff (rst)
    clk_en && cfg_load && !range_bad |=> cond_ff == $past(switch_condition_select) && !cfg_range_err)
    else $error("Accepted settings were not stored");
  chk_reject_keeps: assert property (@(posedge clock) disable iff (rst)
    clk_en && cfg_load && range_bad |=> $stable(tq_lvl_ff) && $stable(cond_ff) && cfg_range_err)
    else $error("Rejected settings changed stored state");
  chk_err_hold: assert property (@(posedge clock) disable iff (rst)
    clk_en && !cfg_load |=> $stable(cfg_range_err))
    else $error("Range error changed without a load");
  chk_cond_legal: assert property (@(posedge clock) disable iff (rst)
    cond_ff <= pims_pkg::COND_OFF)
    else $error("Stored condition code is illegal");

  // Reset must bring back the documented defaults, whatever was loaded before
  chk_reset_level: assert property (@(posedge clock)
    rst |=> tq_lvl_ff == pims_pkg::TORQUE_LVL_RST && cond_ff == pims_pkg::COND_RST && !p_only)
    else $error("Reset did not restore default settings");

  // A frozen block must not drift, or the loop would switch mid-cycle
  chk_hold_frozen: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(p_only) && $stable(cond_ff) && $stable(pos_integral_en))
    else $error("State changed while clock enable was low");

  // Integral outputs track the stored constant one cycle later
  chk_pit_follow: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> pos_integral_time_out == $past(pit_ff))
    else $error("Integral time output lags stored value");
  chk_pi_nonzero_on: assert property (@(posedge clock) disable iff (rst)
    clk_en && pit_ff != 16'h0000 |=> pos_integral_en)
    else $error("Integral disabled with nonzero time constant");

  cov_torque_p: cover property (@(posedge clock) disable iff (rst)
    cond_ff == pims_pkg::COND_TORQUE && $rose(p_only));
  cov_speed_linear: cover property (@(posedge clock) disable iff (rst)
    cond_ff == pims_pkg::COND_SPEED && linear_motor && p_only);
  cov_dev_p: cover property (@(posedge clock) disable iff (rst)
    cond_ff == pims_pkg::COND_DEV && p_only);
  cov_cfg_err: cover property (@(posedge clock) disable iff (rst) $rose(cfg_range_err));
  // Freeze while proportional-only is held is the case most likely to glitch
  cov_frozen_p: cover property (@(posedge clock) disable iff (rst)
    !clk_en && p_only);

endmodule // pims_top

`default_nettype wire

// File: verification/pims_loop_model.sv
`timescale 1ns/1ps
`default_nettype none
module pims_loop_model (
  input wire logic clock,
  input wire logic p_only,
  output logic [15:0] p_cycles
);
  // Counts loop cycles spent without integral action
  initial p_cycles = 16'h0000;
  always @(posedge clock)
  begin
    if (p_only === 1'b1)
      p_cycles <= p_cycles + 16'h0001;
  end
endmodule // pims_loop_model
`default_nettype wire

// File: verification/pims_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pims_top_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sel;
  logic [15:0] lv [7];
  logic lin, pmode, ld;
  logic signed [31:0] r [4];
  logic p_only, pie, err;
  logic [15:0] pit_out;
  logic [15:0] pcyc;
  logic en = 1'b1;
  int errors = 0;
  int comparisons = 0;
  pims_top dut_u (.clock(clock), .rst(rst), .clk_en(en), .switch_condition_select(sel),
    .torque_switch_level(lv[0]), .rotary_speed_switch_level(lv[1]), .rotary_accel_switch_level(lv[2]),
    .deviation_switch_level(lv[3]), .linear_speed_switch_level(lv[4]), .linear_accel_switch_level(lv[5]),
    .position_integral_time(lv[6]), .linear_motor(lin), .position_mode(pmode), .cfg_load(ld),
    .torque_ref(r[0]), .speed_ref(r[1]), .accel_ref(r[2]), .position_dev(r[3]), .p_only(p_only),
    .pos_integral_en(pie), .pos_integral_time_out(pit_out), .cfg_range_err(err));
  pims_loop_model loop_u (.clock(clock), .p_only(p_only), .p_cycles(pcyc));
  initial forever #2 clock = ~clock;
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Settings are stored on the load edge; p_only reflects them one edge later
  task automatic load(input logic [3:0] s, input int k, input logic [15:0] v);
    @(posedge clock);
    #1 sel = s;
    lv[k] = v;
    ld = 1'b1;
    @(posedge clock);
    #1 ld = 1'b0;
  endtask
  task automatic put(input int k, input logic signed [31:0] v, input logic exp);
    @(posedge clock);
    #1 foreach (r[i]) r[i] = 32'sh0;
    r[k] = v;
    @(posedge clock);
    #1 check("p_only", {15'h0000, p_only}, {15'h0000, exp});
  endtask
  task automatic t_reset();
    check("outputs", {13'h0000, p_only, pie, err}, 16'h0000);
    put(0, 200, 1'b1);
    put(0, 199, 1'b0);
    put(0, -200, 1'b1);
    $display("done reset defaults");
  endtask
  task automatic t_conds();
    pmode = 1'b1;
    for (int k = 1; k < 4; k++)
    begin
      load(k[3:0], k, 16'h0064);
      put(k, 100, 1'b1);
      put(k, 99, 1'b0);
      put(0, 800, 1'b0);
    end
    $display("done conditions");
  endtask
  task automatic t_linear();
    lin = 1'b1;
    load(4'h1, 4, 16'h012c);
    put(1, 300, 1'b1);
    put(1, 299, 1'b0);
    load(4'h2, 5, 16'h01f4);
    put(2, 500, 1'b1);
    put(2, 499, 1'b0);
    load(4'h0, 0, 16'h0032);
    put(0, 50, 1'b1);
    put(0, 49, 1'b0);
    lin = 1'b0;
    $display("done linear");
  endtask
  task automatic t_dev_mode();
    load(4'h3, 3, 16'h000a);
    pmode = 1'b0;
    put(3, 10000, 1'b0);
    pmode = 1'b1;
    put(3, 10, 1'b1);
    $display("done deviation mode");
  endtask
  task automatic t_off();
    logic [15:0] n;
    load(4'h4, 0, 16'h0000);
    for (int k = 0; k < 4; k++)
      put(k, 32'sh7fffffff, 1'b0);
    n = pcyc;
    put(1, 32'sh7fffffff, 1'b0);
    check("p cycles", pcyc, n);
    $display("done switching off");
  endtask
  task automatic t_pit();
    load(4'h4, 6, 16'hc350);
    @(posedge clock);
    #1 check("integral time", pit_out, 16'hc350);
    check("integral en", {15'h0000, pie}, 16'h0001);
    load(4'h4, 6, 16'h0000);
    @(posedge clock);
    #1 check("integral off", {15'h0000, pie}, 16'h0000);
    $display("done position integral");
  endtask
  task automatic t_range();
    load(4'h0, 0, 16'h0321);
    put(0, 800, 1'b0);
    check("range error", {15'h0000, err}, 16'h0001);
    load(4'h0, 0, 16'h0320);
    put(0, 800, 1'b1);
    put(0, 799, 1'b0);
    check("range error", {15'h0000, err}, 16'h0000);
    $display("done range");
  endtask
  task automatic t_freeze();
    put(0, 800, 1'b1);
    @(posedge clock);
    #1 en = 1'b0;
    r[0] = 32'sh0;
    repeat (2) @(posedge clock);
    #1 check("frozen p_only", {15'h0000, p_only}, 16'h0001);
    en = 1'b1;
    @(posedge clock);
    #1 check("thawed p_only", {15'h0000, p_only}, 16'h0000);
    $display("done freeze");
  endtask
  task automatic t_rerun();
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check("outputs after reset", {13'h0000, p_only, pie, err}, 16'h0000);
    put(0, 200, 1'b1);
    put(0, 199, 1'b0);
    $display("done second reset");
  endtask
  initial
  begin
    sel = 4'h0;
    lv = '{16'h00c8, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    lin = 1'b0;
    pmode = 1'b0;
    ld = 1'b0;
    r = '{32'sh0, 32'sh0, 32'sh0, 32'sh0};
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_conds();
    t_linear();
    t_dev_mode();
    t_off();
    t_pit();
    t_range();
    t_freeze();
    t_rerun();
    test_done();
  end
  // Whole run needs about a hundred cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule // pims_top_tb
`default_nettype wire
